// [rtl/mmsd_decoder.sv]
// Program and internal data memory space decoder for an 8-bit core.
`timescale 1ns/1ps
// What this block does
// R1: Program space is read only; writes into it are dropped and flagged.
// R2: Sixteen-bit program counter over 64K, only 8K implemented.
// R3: After reset the first fetch is from address 0000H.
// R4: Each interrupt has a fixed vector; taking one redirects fetch there.
// R5: External interrupt zero enters at 0003H.
// R6: Consecutive vectors lie eight bytes apart.
// R7: Unused vector locations are ordinary program memory.
// R8: Internal data addresses are one byte, a 256-byte space with stack.
// R9: A full 16-bit data address comes from the data pointer.
// R10: Above 7FH direct reaches special functions, indirect reaches upper RAM.
// R11: Lowest 32 bytes are four banks of eight working registers.
// R12: Two status word bits pick the bank used by register accesses.
// R13: Bank selects are status bits four and three, writable, reset zero.
// R14: Bytes 20H to 2FH give bits 00H to 7FH.
// R15: Lower 128 bytes reachable directly and indirectly.
// R16: Upper 128 bytes reachable only indirectly.
// R17: Special function bytes with low bits 000 are bit addressable.
// R18: Fetches above 8K ignore unused upper bits without error or stall.
module mmsd_decoder
  import mmsd_pkg::*;
#(
  parameter int PROG_WIDTH = PROG_IMPL_WIDTH
)
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  input  wire logic              fetch_req,
  input  wire logic              jump_req,
  input  wire logic [15:0]       jump_addr,
  input  wire logic              int_take,
  input  wire logic [4:0]        int_num,
  input  wire logic              prog_write_req,
  input  wire mmsd_data_req_type data_req,
  input  wire logic [15:0]       data_pointer,
  input  wire logic              psw_write,
  input  wire logic [7:0]        psw_wdata,
  output logic [15:0]            pc_r,
  output logic                   prog_rd_r,
  output logic [PROG_WIDTH-1:0]  prog_addr_r,
  output logic                   prog_write_err_r,
  output mmsd_data_dec_type      data_dec_r,
  output logic [7:0]             program_status_word_r
);

  // ---------------------------------------------------------------------------
  // Program counter and fetch
  // ---------------------------------------------------------------------------
  logic [15:0] vector_addr;
  logic [15:0] pc_nxt;

  // Vectors are spaced by eight bytes from the first interrupt entry.
  assign vector_addr = EXT0_VECTOR + VECTOR_SPACING * {11'h000, int_num}; // R4 R5 R6

  // Interrupt entry wins over a jump, a jump over a plain increment.
  always_comb
  begin
    pc_nxt = pc_r;
    if (int_take)
      pc_nxt = vector_addr; // R4
    else if (jump_req)
      pc_nxt = jump_addr;
    else if (fetch_req)
      pc_nxt = pc_r + 16'h0001; // R2
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pc_r <= RESET_VECTOR; // R3
    else
      pc_r <= pc_nxt;
  end

  // Only a fetch reads program space, and every address maps without stalling.
  // The fetch address is the counter before it advances, so reset fetches 0000H.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prog_rd_r   <= 1'b0;
      prog_addr_r <= '0;
    end
    else
    begin
      prog_rd_r   <= fetch_req; // R1 R7
      prog_addr_r <= pc_r[PROG_WIDTH-1:0]; // R18 R2 R3
    end
  end

  // There is no write path into program space; an attempt only raises a flag.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      prog_write_err_r <= 1'b0;
    else
      prog_write_err_r <= prog_write_req; // R1
  end

  // ---------------------------------------------------------------------------
  // Program status word
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      program_status_word_r <= PSW_RESET; // R13
    else if (psw_write)
      program_status_word_r <= psw_wdata; // R13
  end

  // ---------------------------------------------------------------------------
  // Data access decode
  // ---------------------------------------------------------------------------
  logic [1:0]        bank_sel;
  mmsd_data_dec_type dec_nxt;

  assign bank_sel = {program_status_word_r[PSW_BANK_HIGH], program_status_word_r[PSW_BANK_LOW]}; // R12 R13

  always_comb
  begin
    dec_nxt            = '0;
    dec_nxt.valid      = data_req.valid;
    dec_nxt.write      = data_req.write;
    dec_nxt.target     = MMSD_TGT_NONE;
    case (data_req.mode)
      MMSD_REGISTER:
      begin
        // Register numbers zero to seven land in the selected bank.
        dec_nxt.target = MMSD_TGT_LOWER; // R11 R12
        dec_nxt.addr   = {11'h000, bank_sel, data_req.addr[2:0]}; // R11
      end
      MMSD_INDIRECT:
      begin
        // Indirect reaches lower RAM below 80H and upper RAM above.
        if (data_req.addr >= UPPER_BASE)
          dec_nxt.target = MMSD_TGT_UPPER; // R10 R16
        else
          dec_nxt.target = MMSD_TGT_LOWER; // R15
        dec_nxt.addr = {8'h00, data_req.addr}; // R8
      end
      MMSD_DIRECT:
      begin
        if (data_req.addr >= UPPER_BASE)
          dec_nxt.target = MMSD_TGT_SFR; // R10 R16
        else
          dec_nxt.target = MMSD_TGT_LOWER; // R15
        dec_nxt.addr = {8'h00, data_req.addr}; // R8
      end
      MMSD_BIT:
      begin
        dec_nxt.bit_access = 1'b1;
        dec_nxt.bit_pos    = data_req.addr[2:0];
        if (data_req.addr < UPPER_BASE)
        begin
          // Bit n lives in byte 20H plus n divided by eight.
          dec_nxt.target = MMSD_TGT_LOWER; // R14
          dec_nxt.addr   = {8'h00, BIT_AREA_BASE + {4'h0, data_req.addr[6:3]}}; // R14
        end
        else
        begin
          // Bits above 7FH select a special function byte on an eight-byte boundary.
          dec_nxt.target = MMSD_TGT_SFR; // R17
          dec_nxt.addr   = {8'h00, data_req.addr[7:3], SFR_BIT_LOW}; // R17
        end
      end
      MMSD_POINTER:
      begin
        dec_nxt.target = MMSD_TGT_EXT; // R9
        dec_nxt.addr   = data_pointer; // R9
      end
      default:
      begin
        dec_nxt.illegal = data_req.valid;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      data_dec_r <= '0;
    else
      data_dec_r <= dec_nxt;
  end

endmodule

// [rtl/mmsd_pkg.sv]
// Package for the memory space decoder: constants, modes and carrier structs.
package mmsd_pkg;

  // ---------------------------------------------------------------------------
  // Program space
  // ---------------------------------------------------------------------------
  localparam int          PC_WIDTH         = 16;
  localparam int          PROG_IMPL_WIDTH  = 13;
  localparam logic [15:0] RESET_VECTOR     = 16'h0000;
  localparam logic [15:0] EXT0_VECTOR      = 16'h0003;
  localparam logic [15:0] VECTOR_SPACING   = 16'h0008;
  localparam int          VEC_NUM_WIDTH    = 5;

  // ---------------------------------------------------------------------------
  // Internal data space
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  UPPER_BASE       = 8'h80;
  localparam logic [7:0]  BANK_AREA_TOP    = 8'h1F;
  localparam logic [7:0]  BIT_AREA_BASE    = 8'h20;
  localparam logic [7:0]  BIT_AREA_TOP     = 8'h2F;
  localparam int          PSW_BANK_HIGH    = 4;
  localparam int          PSW_BANK_LOW     = 3;
  localparam logic [7:0]  PSW_RESET        = 8'h00;
  localparam logic [2:0]  SFR_BIT_LOW      = 3'h0;

  // Kind of data access issued by the core, internal or external through the data pointer.
  typedef enum logic [2:0] {
    MMSD_DIRECT   = 3'h0,
    MMSD_INDIRECT = 3'h1,
    MMSD_REGISTER = 3'h2,
    MMSD_BIT      = 3'h3,
    MMSD_POINTER  = 3'h4
  } mmsd_mode_type;

  // Target space of a decoded data access.
  typedef enum logic [3:0] {
    MMSD_TGT_NONE  = 4'h0,
    MMSD_TGT_LOWER = 4'h1,
    MMSD_TGT_UPPER = 4'h2,
    MMSD_TGT_SFR   = 4'h4,
    MMSD_TGT_EXT   = 4'h8
  } mmsd_target_type;

  typedef struct packed {
    logic          valid;
    logic          write;
    mmsd_mode_type mode;
    logic [7:0]    addr;
  } mmsd_data_req_type;

  typedef struct packed {
    logic            valid;
    logic            write;
    mmsd_target_type target;
    logic [15:0]     addr;
    logic [2:0]      bit_pos;
    logic            bit_access;
    logic            illegal;
  } mmsd_data_dec_type;

endpackage

// [test/mmsd_chk.sv]
// Port checker for the decoder.
`timescale 1ns/1ps
module mmsd_chk
  import mmsd_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              fetch_req,
  input wire logic              jump_req,
  input wire logic              int_take,
  input wire logic [4:0]        int_num,
  input wire logic              prog_write_req,
  input wire mmsd_data_req_type data_req,
  input wire logic              psw_write,
  input wire logic [15:0]       pc_r,
  input wire logic              prog_write_err_r,
  input wire mmsd_data_dec_type data_dec_r,
  input wire logic [7:0]        program_status_word_r
);
  // ------
  // Checks
  // ------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] a;
  logic [3:0] nib;
  logic [2:0] lo;
  logic [1:0] bank;
  logic       dv;
  assign a    = data_req.addr;
  assign nib  = a[6:3];
  assign lo   = a[2:0];
  assign bank = program_status_word_r[4:3];
  assign dv   = data_req.valid;
  pc_step_a: assert property (
    fetch_req && !jump_req && !int_take |=> pc_r == $past(pc_r) + 16'h0001) else $error("pc step");
  vector_a: assert property (
    int_take |=> pc_r == 16'h0003 + 16'h0008 * $past(int_num)) else $error("vector");
  pwrite_a: assert property (
    prog_write_req && !int_take && !jump_req && !fetch_req |=> prog_write_err_r && $stable(pc_r)) else $error("pwrite");
  direct_a: assert property (
    dv && a[7] && data_req.mode == MMSD_DIRECT |=> data_dec_r.target == MMSD_TGT_SFR) else $error("direct");
  indirect_a: assert property (
    dv && data_req.mode == MMSD_INDIRECT |=> data_dec_r.target == ($past(a[7]) ? MMSD_TGT_UPPER : MMSD_TGT_LOWER))
    else $error("indirect");
  bank_a: assert property (
    dv && data_req.mode == MMSD_REGISTER && !psw_write |=> data_dec_r.addr == {11'h000, $past(bank), $past(lo)})
    else $error("bank");
  bit_area_a: assert property (
    dv && !a[7] && data_req.mode == MMSD_BIT |=> data_dec_r.addr == 16'h0020 + $past(nib)) else $error("bit area");
  sfr_bit_a: assert property (
    dv && a[7] && data_req.mode == MMSD_BIT |=> data_dec_r.addr == {8'h00, $past(a) & 8'hF8}) else $error("sfr bit");
  cover property (int_take && int_num == 5'h1F);
  cover property (dv && data_req.mode == MMSD_REGISTER && bank == 2'h3);
  cover property (prog_write_req);
endmodule
bind mmsd_decoder mmsd_chk mmsd_chk_i (.*);

// [test/mmsd_core.sv]
// Core-side model that issues fetches and data accesses.
`timescale 1ns/1ps
module mmsd_core
  import mmsd_pkg::*;
(
  input  wire logic        ref_clk,
  output logic             fetch_req,
  output logic             jump_req,
  output logic [15:0]      jump_addr,
  output logic             int_take,
  output logic [4:0]       int_num,
  output logic             prog_write_req,
  output mmsd_data_req_type data_req,
  output logic [15:0]      data_pointer,
  output logic             psw_write,
  output logic [7:0]       psw_wdata
);
  // -------------
  // Request issue
  // -------------
  initial
  begin
    {fetch_req, jump_req, int_take, prog_write_req, psw_write} = 5'h00;
    {jump_addr, int_num, data_pointer, psw_wdata} = 45'h0;
    data_req = 13'h0000;
  end
  // Every call sets every request line, so back-to-back calls never drive a line twice in one step.
  task automatic issue(input logic [4:0] s, input logic [15:0] v, input mmsd_data_req_type d);
    {fetch_req, jump_req, int_take, prog_write_req, psw_write} = s;
    {jump_addr, int_num, data_pointer, psw_wdata} = {v, v[4:0], v, v[7:0]};
    data_req = d;
    @(posedge ref_clk);
    #1;
  endtask
endmodule

// [test/mmsd_decoder_tb_top.sv]
// Self-checking bench for the memory space decoder.
`timescale 1ns/1ps
module mmsd_decoder_tb_top
  import mmsd_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  int                n_fail = 0;
  int                total_checks = 0;
  logic              fetch_req, jump_req, int_take, prog_write_req, psw_write, prog_rd_r, prog_write_err_r;
  logic [4:0]        int_num;
  logic [7:0]        psw_wdata, program_status_word_r;
  logic [12:0]       prog_addr_r;
  logic [15:0]       jump_addr, data_pointer, pc_r, p;
  mmsd_data_req_type data_req;
  mmsd_data_dec_type data_dec_r;
  mmsd_core          mmsd_core_i (.*);
  mmsd_decoder       mmsd_decoder_i (.*);
  // --------
  // Scenarios
  // --------
  task automatic final_report();
    if (n_fail == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [4:0] s, input logic [15:0] v);
    mmsd_core_i.issue(s, v, 13'h0000);
  endtask
  task automatic dat(input mmsd_mode_type m, input logic [7:0] a, input mmsd_target_type t, input logic [15:0] e);
    mmsd_core_i.issue(5'h00, 16'h1234, {1'b1, 1'b0, m, a});
    chk({12'h000, data_dec_r.target}, {12'h000, t});
    chk(data_dec_r.addr, e);
    chk({10'h000, data_dec_r.illegal, data_dec_r.valid, data_dec_r.bit_access, data_dec_r.bit_pos},
        {10'h000, m > MMSD_POINTER, 1'b1, m == MMSD_BIT, (m == MMSD_BIT) ? a[2:0] : 3'h0});
  endtask
  task automatic t_reset();
    chk({8'h00, program_status_word_r}, 16'h0000);
    op(5'h10, 16'h0000);
    chk({3'h0, prog_addr_r}, 16'h0000);
    chk(pc_r, 16'h0001);
  endtask
  task automatic t_vector();
    foreach (p[i])
    begin
      op(5'h1C, 16'(i * 2 + 1));
      chk(pc_r, 16'h0003 + 16'h0008 * (i * 2 + 1));
    end
    op(5'h10, 16'h0000);
    chk({3'h0, prog_addr_r}, 16'h0003 + 16'h0008 * 1);
  endtask
  task automatic t_jump();
    op(5'h18, 16'hE005);
    chk(pc_r, 16'hE005);
    op(5'h10, 16'h0000);
    chk({2'h0, prog_rd_r, prog_addr_r}, 16'h2005);
    chk(pc_r, 16'hE006);
  endtask
  task automatic t_pwrite();
    p = pc_r;
    op(5'h02, 16'h0000);
    chk({prog_write_err_r, 15'h0000}, 16'h8000);
    chk(pc_r, p);
  endtask
  task automatic t_space();
    dat(MMSD_DIRECT, 8'h90, MMSD_TGT_SFR, 16'h0090);
    dat(MMSD_INDIRECT, 8'h90, MMSD_TGT_UPPER, 16'h0090);
    dat(MMSD_DIRECT, 8'h10, MMSD_TGT_LOWER, 16'h0010);
    dat(MMSD_INDIRECT, 8'h7F, MMSD_TGT_LOWER, 16'h007F);
    dat(MMSD_BIT, 8'h00, MMSD_TGT_LOWER, 16'h0020);
    dat(MMSD_BIT, 8'h7F, MMSD_TGT_LOWER, 16'h002F);
    dat(MMSD_BIT, 8'h8A, MMSD_TGT_SFR, 16'h0088);
    dat(MMSD_POINTER, 8'h00, MMSD_TGT_EXT, 16'h1234);
    dat(mmsd_mode_type'(3'h5), 8'h00, MMSD_TGT_NONE, 16'h0000);
  endtask
  task automatic t_bank();
    op(5'h01, 16'h0010);
    chk({8'h00, program_status_word_r}, 16'h0010);
    dat(MMSD_REGISTER, 8'h05, MMSD_TGT_LOWER, 16'h0015);
    op(5'h01, 16'h0018);
    dat(MMSD_REGISTER, 8'h07, MMSD_TGT_LOWER, 16'h001F);
  endtask
  initial
    forever #25 ref_clk = ~ref_clk;
  // The run is under a hundred cycles, so this span only trips on a hang.
  initial
  begin
    #20000;
    n_fail++;
    final_report();
  end
  initial
  begin
    repeat (10) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_vector();
    t_jump();
    t_pwrite();
    t_space();
    t_bank();
    final_report();
  end
endmodule
